/* File: shared/spct_pkg.sv */
// Shared constants for the serial peripheral timing and interrupt block
package spct_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_MODE  = 8'h04;
    localparam logic [7:0] OFS_RXD   = 8'h08;
    localparam logic [7:0] OFS_TXD   = 8'h0C;
    localparam logic [7:0] OFS_STAT  = 8'h10;
    localparam logic [7:0] OFS_IESET = 8'h14;
    localparam logic [7:0] OFS_IECLR = 8'h18;
    localparam logic [7:0] OFS_IMASK = 8'h1C;
    localparam logic [7:0] OFS_CFG0  = 8'h30;
    localparam logic [7:0] OFS_CFG3  = 8'h3C;
    // Interrupt bit layout
    localparam int IRQ_W       = 8;
    localparam int B_RX_READY  = 0;
    localparam int B_TX_EMPTY  = 1;
    localparam int B_FAULT     = 2;
    localparam int B_OVERRUN   = 3;
    localparam int B_DMA_LSB   = 4;
    // Control and mode fields
    localparam int C_EN_BIT    = 0;
    localparam int C_DIS_BIT   = 1;
    localparam int M_PRE_BIT   = 3;
    localparam int M_DEC_BIT   = 2;
    localparam int M_SEL_LSB   = 16;
    // Chip-select configuration fields
    localparam int F_ICD_LSB   = 24;
    localparam int F_SCD_LSB   = 16;
    localparam int F_DIV_LSB   = 8;
    localparam int F_LEN_LSB   = 4;
    localparam int F_PHASE_BIT = 1;
    localparam int F_IDLE_BIT  = 0;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    // Timing limits, counts and shift amounts (log2 of multipliers) in master clocks
    localparam int         CNT_W       = 20;
    localparam logic [7:0] DIV_MIN     = 8'h02;
    localparam logic [4:0] BASE_BITS   = 5'h08;
    localparam logic [4:0] PRE_MUL     = 5'h05;
    localparam logic [4:0] GAP_MUL     = 5'h05;
    localparam logic [4:0] GAP_MUL_PRE = 5'h0A;
    localparam logic [CNT_W-1:0] GAP_MIN     = 20'h00004;
    localparam logic [CNT_W-1:0] GAP_MIN_PRE = 20'h00080;
    // Bus answers
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [1:0] {S_IDLE, S_LEAD, S_SHIFT, S_GAP} spct_state_t;
endpackage : spct_pkg

/* File: src/spct_core.sv */
// Serial peripheral master: per-select timing, serializer, interrupt regs
// Behaviour
// - Enable-set write sets masks for ones
// - Enable-clear write clears masks for ones
// - Mask view reads current enabled sources
// - Shared layout of eight interrupt bits
// - Idle level bit sets inactive clock level
// - Phase zero: change leading, sample trailing
// - Phase one: sample leading, change trailing
// - Length code zero to eight gives eight to sixteen bits
// - Clock divides by 2 or 64 times divider
// - Divider below two stops the clock
// - Select-to-clock delay, half period default
// - Inter-character gap, scaled by prescaler
// - Gap after every character, select kept
// - Prescale bit runs timing at clock/32
// - Decode uses register n for 4n..4n+3
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spct_core (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // AXI4-Lite slave
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    // Unit events
    input  wire logic        i_conflict,
    input  wire logic [3:0]  i_dma_evt,
    // Serial link
    output logic             o_serial_clock_out,
    output logic             o_mosi,
    input  wire logic        i_miso,
    output logic [3:0]       o_peripheral_select_n,
    // Interrupt
    output logic             o_irq
);
    typedef logic [spct_pkg::CNT_W-1:0] spct_cnt_t;

    logic [31:0] cfg_reg [4];
    logic [31:0] mode_reg;
    logic        enable_reg;
    logic [7:0]  mask_reg;
    logic [7:0]  status_reg;
    logic [15:0] txd_reg;
    logic        tx_full_reg;
    logic [15:0] rxd_reg;
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [7:0]  waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    spct_pkg::spct_state_t state_reg;
    logic [1:0]  act_idx_reg;
    logic [3:0]  sel_n_reg;
    logic [15:0] tx_sh_reg;
    logic [15:0] rx_sh_reg;
    logic [4:0]  edge_reg;
    logic        sclk_reg;
    logic        mosi_reg;
    logic        irq_reg;

    // Byte-lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        return r;
    endfunction : merge

    // Configuration register that governs a given select value
    function automatic logic [1:0] cfg_index(input logic       dec,
                                             input logic [3:0] pcs);
        if (dec)
            return pcs[3:2];
        else if (!pcs[0])
            return 2'h0;
        else if (!pcs[1])
            return 2'h1;
        else if (!pcs[2])
            return 2'h2;
        else
            return 2'h3;
    endfunction : cfg_index

    // Field value scaled by a power of two, in master clocks
    function automatic spct_cnt_t scale(input logic [7:0] v,
                                        input logic [4:0] sh);
        return spct_cnt_t'({12'h000, v} << sh);
    endfunction : scale

    // Offset falls on one of the four select configuration registers
    function automatic logic is_cfg(input logic [7:0] a);
        return a >= spct_pkg::OFS_CFG0 && a <= spct_pkg::OFS_CFG3;
    endfunction : is_cfg

    // Settings of the select in use
    logic [31:0] cfg_act;
    logic        pre;
    logic [7:0]  div_f;
    logic [7:0]  scd_f;
    logic [7:0]  icd_f;
    logic [4:0]  nbits;
    logic        phase;
    logic [1:0]  new_idx;
    logic [31:0] cfg_new;
    spct_cnt_t   half_cnt;
    spct_cnt_t   lead_cnt;
    spct_cnt_t   gap_cnt;

    assign pre     = mode_reg[spct_pkg::M_PRE_BIT];
    assign new_idx = cfg_index(mode_reg[spct_pkg::M_DEC_BIT],
                               mode_reg[spct_pkg::M_SEL_LSB +: 4]);
    assign cfg_new = cfg_reg[new_idx];
    // The index is latched only at start, so idle timing uses the new select
    assign cfg_act = (state_reg == spct_pkg::S_IDLE) ? cfg_new
                                                     : cfg_reg[act_idx_reg];
    assign div_f   = cfg_act[spct_pkg::F_DIV_LSB +: 8];
    assign scd_f   = cfg_act[spct_pkg::F_SCD_LSB +: 8];
    assign icd_f   = cfg_act[spct_pkg::F_ICD_LSB +: 8];
    assign phase   = cfg_act[spct_pkg::F_PHASE_BIT];
    assign nbits   = spct_pkg::BASE_BITS
                   + {1'b0, cfg_act[spct_pkg::F_LEN_LSB +: 4]};
    // Half a serial period is divider or 32 x divider master clocks
    assign half_cnt = scale(div_f, pre ? spct_pkg::PRE_MUL : 5'h00);
    assign lead_cnt = (scd_f == 8'h00) ? half_cnt
                    : scale(scd_f, pre ? spct_pkg::PRE_MUL : 5'h00);
    assign gap_cnt  = (icd_f == 8'h00)
                    ? (pre ? spct_pkg::GAP_MIN_PRE : spct_pkg::GAP_MIN)
                    : scale(icd_f, pre ? spct_pkg::GAP_MUL_PRE
                                       : spct_pkg::GAP_MUL);

    // Bus handshakes
    logic wr_go;
    logic rd_go;
    logic wr_map;
    assign o_s_axi_awready = !aw_full_reg;
    assign o_s_axi_wready  = !w_full_reg;
    assign o_s_axi_arready = !rvalid_reg;
    assign o_s_axi_bvalid  = bvalid_reg;
    assign o_s_axi_bresp   = bresp_reg;
    assign o_s_axi_rvalid  = rvalid_reg;
    assign o_s_axi_rdata   = rdata_reg;
    assign o_s_axi_rresp   = rresp_reg;
    assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    assign rd_go = i_s_axi_arvalid && !rvalid_reg;
    assign wr_map = (waddr_reg <= spct_pkg::OFS_IMASK) || is_cfg(waddr_reg);

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            waddr_reg   <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= spct_pkg::RESP_OK;
        end
        else
        begin
            if (i_s_axi_awvalid && !aw_full_reg)
            begin
                aw_full_reg <= 1'b1;
                waddr_reg   <= {i_s_axi_awaddr[7:2], 2'b00};
            end
            if (i_s_axi_wvalid && !w_full_reg)
            begin
                w_full_reg <= 1'b1;
                wdata_reg  <= i_s_axi_wdata;
                wstrb_reg  <= i_s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_map ? spct_pkg::RESP_OK
                                      : spct_pkg::RESP_ERR;
            end
            else if (bvalid_reg && i_s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // Read mux; bits above the RXD, STAT and IMASK fields read zero
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= spct_pkg::RESP_OK;
        end
        else if (rd_go)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= spct_pkg::RESP_OK;
            rdata_reg  <= 32'h0000_0000;
            case ({i_s_axi_araddr[7:2], 2'b00})
                spct_pkg::OFS_MODE:  rdata_reg <= mode_reg;
                spct_pkg::OFS_RXD:   rdata_reg <= {16'h0000, rxd_reg};
                spct_pkg::OFS_STAT:  rdata_reg <= {24'h000000, status_reg};
                spct_pkg::OFS_IMASK: rdata_reg <= {24'h000000, mask_reg};
                spct_pkg::OFS_CTRL, spct_pkg::OFS_TXD,
                spct_pkg::OFS_IESET, spct_pkg::OFS_IECLR:
                    rdata_reg <= 32'h0000_0000;
                default:
                    if (is_cfg({i_s_axi_araddr[7:2], 2'b00}))
                        rdata_reg <= cfg_reg[i_s_axi_araddr[3:2]];
                    else
                        rresp_reg <= spct_pkg::RESP_ERR;
            endcase
        end
        else if (rvalid_reg && i_s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // Configuration and mode registers
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            mode_reg <= spct_pkg::MODE_RESET;
            for (int i = 0; i < 4; i++)
                cfg_reg[i] <= spct_pkg::CFG_RESET;
        end
        else if (wr_go)
        begin
            if (waddr_reg == spct_pkg::OFS_MODE)
                mode_reg <= merge(mode_reg, wdata_reg, wstrb_reg);
            if (is_cfg(waddr_reg))
                cfg_reg[waddr_reg[3:2]] <= merge(cfg_reg[waddr_reg[3:2]],
                                                 wdata_reg, wstrb_reg);
        end
    end

    // Interrupt mask: set and clear ports never store a value of their own
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            mask_reg <= 8'h00;
        else if (wr_go && wstrb_reg[0])
        begin
            if (waddr_reg == spct_pkg::OFS_IESET)
                mask_reg <= mask_reg | wdata_reg[7:0];
            else if (waddr_reg == spct_pkg::OFS_IECLR)
                mask_reg <= mask_reg & ~wdata_reg[7:0];
        end
    end

    // Enable: disable wins when both are written at once
    logic wr_ctrl;
    logic wr_txd;
    assign wr_ctrl = wr_go && waddr_reg == spct_pkg::OFS_CTRL && wstrb_reg[0];
    assign wr_txd  = wr_go && waddr_reg == spct_pkg::OFS_TXD;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            enable_reg <= 1'b0;
        else if (wr_ctrl && wdata_reg[spct_pkg::C_DIS_BIT])
            enable_reg <= 1'b0;
        else if (wr_ctrl && wdata_reg[spct_pkg::C_EN_BIT])
            enable_reg <= 1'b1;
    end

    // Transfer engine
    logic start;
    logic timer_done;
    logic timer_load;
    spct_cnt_t timer_cnt;
    logic do_edge;
    logic last_edge;
    logic sample_edge;
    logic xfer_end;
    logic [15:0] rx_next;

    // A divider below two leaves the engine idle and the clock parked
    assign start = (state_reg == spct_pkg::S_IDLE) && enable_reg
                && tx_full_reg
                && cfg_new[spct_pkg::F_DIV_LSB +: 8] >= spct_pkg::DIV_MIN;
    assign do_edge = timer_done && (state_reg == spct_pkg::S_LEAD
                                 || state_reg == spct_pkg::S_SHIFT);
    assign last_edge = edge_reg == 5'(({1'b0, nbits} << 1) - 6'h01);
    // Leading edges are the even ones
    assign sample_edge = (edge_reg[0] != phase);
    assign rx_next = sample_edge ? {rx_sh_reg[14:0], i_miso} : rx_sh_reg;
    assign xfer_end = do_edge && last_edge;
    assign timer_load = start || do_edge
                     || (state_reg == spct_pkg::S_GAP && timer_done);
    assign timer_cnt = start ? lead_cnt : xfer_end ? gap_cnt : half_cnt;

    spct_timer u_timer (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_load  (timer_load),
        .i_count (timer_cnt),
        .o_done  (timer_done)
    );

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_reg   <= spct_pkg::S_IDLE;
            act_idx_reg <= 2'h0;
            sel_n_reg   <= 4'hF;
        end
        else
        begin
            case (state_reg)
                spct_pkg::S_IDLE:
                    if (start)
                    begin
                        state_reg   <= spct_pkg::S_LEAD;
                        act_idx_reg <= new_idx;
                        sel_n_reg   <= mode_reg[spct_pkg::M_DEC_BIT]
                                     ? mode_reg[spct_pkg::M_SEL_LSB +: 4]
                                     : ~(4'h1 << new_idx);
                    end
                spct_pkg::S_LEAD:
                    if (do_edge)
                        state_reg <= spct_pkg::S_SHIFT;
                spct_pkg::S_SHIFT:
                    if (xfer_end)
                        state_reg <= spct_pkg::S_GAP;
                spct_pkg::S_GAP:
                    if (timer_done)
                    begin
                        // Back-to-back data keeps the same select asserted
                        if (enable_reg && tx_full_reg)
                            state_reg <= spct_pkg::S_LEAD;
                        else
                        begin
                            state_reg <= spct_pkg::S_IDLE;
                            sel_n_reg <= 4'hF;
                        end
                    end
                default: state_reg <= spct_pkg::S_IDLE;
            endcase
        end
    end

    // Data load at the start of each character
    logic load_char;
    logic [15:0] tx_left;
    assign load_char = start
                    || (state_reg == spct_pkg::S_GAP && timer_done
                        && enable_reg && tx_full_reg);
    assign tx_left = txd_reg << (5'h10 - nbits);

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            tx_sh_reg <= 16'h0000;
            rx_sh_reg <= 16'h0000;
            edge_reg  <= 5'h00;
            mosi_reg  <= 1'b0;
            sclk_reg  <= 1'b0;
        end
        else if (load_char)
        begin
            // Phase one puts the first bit out before edge zero
            tx_sh_reg <= phase ? {tx_left[14:0], 1'b0} : tx_left;
            rx_sh_reg <= 16'h0000;
            edge_reg  <= 5'h00;
            mosi_reg  <= tx_left[15];
        end
        else if (do_edge)
        begin
            sclk_reg <= ~sclk_reg;
            edge_reg <= edge_reg + 5'h01;
            if (sample_edge)
                rx_sh_reg <= rx_next;
            else
            begin
                mosi_reg  <= tx_sh_reg[15];
                tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
            end
        end
        else if (state_reg == spct_pkg::S_IDLE)
            sclk_reg <= cfg_new[spct_pkg::F_IDLE_BIT];
    end

    // Transmit holding and receive registers
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            txd_reg     <= 16'h0000;
            tx_full_reg <= 1'b0;
            rxd_reg     <= 16'h0000;
        end
        else
        begin
            if (wr_txd)
            begin
                txd_reg     <= wdata_reg[15:0];
                tx_full_reg <= 1'b1;
            end
            else if (load_char)
                tx_full_reg <= 1'b0;
            if (xfer_end)
                rxd_reg <= rx_next;
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    logic [7:0] events;
    logic [7:0] clr;
    logic       rd_rx;
    assign rd_rx = rd_go && {i_s_axi_araddr[7:2], 2'b00} == spct_pkg::OFS_RXD;
    assign events = {i_dma_evt, status_reg[spct_pkg::B_RX_READY] && xfer_end,
                     i_conflict && enable_reg, load_char, xfer_end};
    assign clr = ((wr_go && waddr_reg == spct_pkg::OFS_STAT && wstrb_reg[0])
                  ? wdata_reg[7:0] : 8'h00)
               | {7'h00, rd_rx};

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            status_reg <= 8'h00;
            irq_reg    <= 1'b0;
        end
        else
        begin
            status_reg <= (status_reg & ~clr) | events;
            irq_reg    <= |(status_reg & mask_reg);
        end
    end

    assign o_serial_clock_out    = sclk_reg;
    assign o_mosi                = mosi_reg;
    assign o_peripheral_select_n = sel_n_reg;
    assign o_irq                 = irq_reg;

    sequence seq_set_write;
        wr_go && waddr_reg == spct_pkg::OFS_IESET && wstrb_reg[0];
    endsequence
    sequence seq_clr_write;
        wr_go && waddr_reg == spct_pkg::OFS_IECLR && wstrb_reg[0];
    endsequence

    AST_MASK_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
        seq_set_write |=> mask_reg == ($past(mask_reg) | $past(wdata_reg[7:0])))
        else $error("mask set write wrong");
    AST_MASK_CLR: assert property (@(posedge i_mclk) disable iff (i_rst)
        seq_clr_write |=> mask_reg == ($past(mask_reg) & ~$past(wdata_reg[7:0])))
        else $error("mask clear write wrong");
    AST_MASK_READ: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_go && i_s_axi_araddr == spct_pkg::OFS_IMASK
        && !(wr_go && wstrb_reg[0] && (waddr_reg == spct_pkg::OFS_IESET
                                       || waddr_reg == spct_pkg::OFS_IECLR))
        |=> rdata_reg[7:0] == mask_reg)
        else $error("mask view differs from mask");
    AST_IRQ: assert property (@(posedge i_mclk) disable iff (i_rst)
        ##1 o_irq == |($past(status_reg) & $past(mask_reg)))
        else $error("irq does not follow flags");
    AST_IDLE_CLK: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_reg == spct_pkg::S_IDLE [*2] |-> o_serial_clock_out
        == $past(cfg_new[spct_pkg::F_IDLE_BIT]))
        else $error("clock not at idle level");
    AST_DIV_OFF: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_reg == spct_pkg::S_IDLE
        && cfg_new[spct_pkg::F_DIV_LSB +: 8] < spct_pkg::DIV_MIN
        |=> state_reg == spct_pkg::S_IDLE)
        else $error("transfer with divider off");
    // Toggles counted on the pin itself, independent of the edge counter
    logic       sclk_q_reg;
    logic [5:0] tog_reg;
    always_ff @(posedge i_mclk)
    begin
        sclk_q_reg <= sclk_reg;
        if (i_rst || load_char)
            tog_reg <= 6'h00;
        else if (sclk_reg != sclk_q_reg)
            tog_reg <= tog_reg + 6'h01;
    end
    AST_LENGTH: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_reg == spct_pkg::S_GAP && timer_done
        |-> tog_reg == {nbits, 1'b0})
        else $error("wrong number of clock edges");
    AST_GAP_SEL: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_reg == spct_pkg::S_SHIFT ##1 state_reg == spct_pkg::S_GAP
        |-> sel_n_reg == $past(sel_n_reg) && sel_n_reg != 4'hF)
        else $error("select dropped before gap");
    AST_SET_WINS: assert property (@(posedge i_mclk) disable iff (i_rst)
        xfer_end |=> status_reg[spct_pkg::B_RX_READY])
        else $error("receive flag lost");
endmodule : spct_core
`default_nettype wire

/* File: src/spct_timer.sv */
// Down counter that pulses once a loaded number of cycles has elapsed
`timescale 1ns/1ps
`default_nettype none
module spct_timer (
    // Clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    // Load and expiry
    input  wire logic                      i_load,
    input  wire logic [spct_pkg::CNT_W-1:0] i_count,
    output logic                           o_done
);
    logic [spct_pkg::CNT_W-1:0] cnt_reg;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            cnt_reg <= '0;
        else if (i_load)
            cnt_reg <= i_count;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
    end

    // Pulse on the last counted cycle so the caller reloads without a gap
    assign o_done = (cnt_reg == {{(spct_pkg::CNT_W-1){1'b0}}, 1'b1});
endmodule : spct_timer
`default_nettype wire

/* File: verification/spct_core_test.sv */
// Bench: registers, interrupt and serial transfers of the core
`timescale 1ns/1ps
`default_nettype none
module spct_core_test;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, pol = 1'b0;
    logic        ph = 1'b0, awready, wready, arready, bvalid, rvalid;
    logic        irq, sclk, mosi, miso;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  sel_n, dma = 4'h0;
    int          err_count = 0, tests_run = 0, cyc = 0, edges = 0, lead, n;
    always #5 clk = ~clk;
    spct_core u_dut (.i_mclk(clk), .i_rst(rst), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1),
        .i_conflict(1'b0), .i_dma_evt(dma), .o_serial_clock_out(sclk),
        .o_mosi(mosi), .i_miso(miso), .o_peripheral_select_n(sel_n),
        .o_irq(irq));
    spct_peer u_peer (.i_sclk(sclk), .i_sel_n(sel_n), .i_mosi(mosi),
        .i_pol(pol), .i_ph(ph), .o_miso(miso), .o_rx(rx));
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Ready is judged before the edge so release lands just after it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b)
        begin
            @(negedge clk);
            aw = awready;
            w = wready;
            b = bvalid;
            resp = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        logic ar, r;
        r = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!r)
        begin
            @(negedge clk);
            ar = arready;
            r = rvalid;
            resp = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end
        chk(rdata & m, e);
    endtask : rd
    task automatic ic(input logic [7:0] a, input logic [31:0] d, input logic e);
        wr(a, d);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : ic
    task automatic xfer(input logic p, input logic q);
        ph <= p;
        pol <= q;
        wr(spct_pkg::OFS_CFG0, {16'h0008, 8'h02, 6'h00, p, q});
        repeat (3) @(posedge clk);
        chk({31'h0, sclk}, {31'h0, q});
        edges = 0;
        lead = 0;
        wr(spct_pkg::OFS_TXD, 32'h0000_00A5);
        for (n = 0; n < 3000 && !(edges > 0 && sel_n == 4'hF); n++)
            @(posedge clk);
        chk(edges, 32'h10);
        chk({31'h0, lead >= 8 && lead <= 10}, 32'h1);
        chk({24'h0, rx}, 32'h0000_00A5);
        rd(spct_pkg::OFS_RXD, 32'h0000_003C, 32'h0000_00FF);
    endtask : xfer
    always @(sclk)
        if (sel_n != 4'hF) edges++;
    always @(posedge clk)
    begin
        cyc++;
        if (sel_n != 4'hF && edges == 0) lead++;
        if (cyc == 5000)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(spct_pkg::OFS_IMASK, 32'h0, ALL);
        wr(spct_pkg::OFS_IESET, 32'h0000_00A5);
        rd(spct_pkg::OFS_IMASK, 32'h0000_00A5, ALL);
        wr(spct_pkg::OFS_IESET, 32'h0000_000A);
        rd(spct_pkg::OFS_IMASK, 32'h0000_00AF, ALL);
        wr(spct_pkg::OFS_IECLR, 32'h0000_0081);
        rd(spct_pkg::OFS_IMASK, 32'h0000_002E, ALL);
        rd(spct_pkg::OFS_CFG3, spct_pkg::CFG_RESET, ALL);
        wr(spct_pkg::OFS_CFG3, 32'hC3B2_0A51);
        rd(spct_pkg::OFS_CFG3, 32'hC3B2_0A51, ALL);
        wr(8'h20, 32'h0000_0001);
        chk({30'h0, resp}, {30'h0, spct_pkg::RESP_ERR});
        rd(8'h20, 32'h0, ALL);
        chk({30'h0, resp}, {30'h0, spct_pkg::RESP_ERR});
        wr(spct_pkg::OFS_IECLR, 32'h0000_00FF);
        dma <= 4'h1;
        @(posedge clk);
        dma <= 4'h0;
        ic(spct_pkg::OFS_IESET, 32'h0000_0010, 1'b1);
        ic(spct_pkg::OFS_IECLR, 32'h0000_0010, 1'b0);
        ic(spct_pkg::OFS_IESET, 32'h0000_0010, 1'b1);
        ic(spct_pkg::OFS_STAT, 32'h0000_0010, 1'b0);
        wr(spct_pkg::OFS_CTRL, 32'h0000_0001);
        xfer(1'b1, 1'b0);
        xfer(1'b0, 1'b1);
        wr(spct_pkg::OFS_CFG0, 32'h0008_0101);
        wr(spct_pkg::OFS_TXD, 32'h0000_005A);
        repeat (60) @(posedge clk);
        chk({27'h0, sel_n, sclk}, 32'h0000_001F);
        summarize();
    end
endmodule : spct_core_test
`default_nettype wire

/* File: verification/spct_peer.sv */
// Peripheral model: shifts a fixed pattern back to the master
`timescale 1ns/1ps
`default_nettype none
module spct_peer (
    // Link from the master
    input  wire logic       i_sclk,
    input  wire logic [3:0] i_sel_n,
    input  wire logic       i_mosi,
    input  wire logic       i_pol,
    input  wire logic       i_ph,
    // Answer
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] sh;
    initial o_miso = 1'b0;
    always @(i_sel_n)
    begin
        sh = 8'h3C;
        o_miso = ~o_miso; // Released line must not keep the old bit
        if (i_sel_n != 4'hF && i_ph)
            {o_miso, sh} = {sh, 1'b0};
    end
    always @(i_sclk)
        if (i_sel_n != 4'hF && (i_sclk != i_pol) == i_ph)
            o_rx = {o_rx[6:0], i_mosi};
        else if (i_sel_n != 4'hF)
            {o_miso, sh} = {sh, 1'b0};
endmodule : spct_peer
`default_nettype wire
